// *** rtl/dpctl_pkg.sv ***
// constants, types and pin bundle for the dual-port memory port controller
// What this block does
// - Reader waits flow delay after opposite write
// - Memory reads assert both chip select and drive
// - Token access: token select low, chip select high
// - Hold writes until contention input has settled
// - Reading 1 means polling; write 1 to withdraw
// - Gap with selects high before token readback
// - Block frees all latches at power-up
// - Never chip select and token select together
package dpctl_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 9;
   localparam int TOKEN_COUNT = 8;
   localparam int TOKEN_SEL_W = 3;
   localparam int SYNC_CYC = 2;

   // port timing in ns; access from slowest speed grade, others plain margins
   localparam int T_ACCESS_NS = 55;
   localparam int T_FLOW_NS = 30;
   localparam int T_ARB_SETTLE_NS = 30;
   localparam int T_TOKEN_GAP_NS = 20;
   localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLOW_CYC = (T_FLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYC = (T_ARB_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC;
   localparam int GAP_CYC = (T_TOKEN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC = ACCESS_CYC + FLOW_CYC + SYNC_CYC;

   localparam logic [12:0] MBOX_TO_RIGHT_ADDR = 13'h1fff;
   localparam logic [12:0] MBOX_TO_LEFT_ADDR = 13'h1ffe;

   // software register offsets
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;

   // status bit positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_CONT_BIT = 2;
   localparam int ST_MBOX_BIT = 3;
   localparam int ST_OWNED_BIT = 4;
   localparam int ST_INIT_BIT = 5;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_MEM_READ = 3'h1,
      CMD_MEM_WRITE = 3'h2,
      CMD_TOKEN_ACQUIRE = 3'h3,
      CMD_TOKEN_RELEASE = 3'h4,
      CMD_TOKEN_READ = 3'h5,
      CMD_MBOX_SEND = 3'h6,
      CMD_MBOX_READ = 3'h7
   } dpctl_cmd_e;

   typedef enum logic [2:0] {
      ST_INIT = 3'h0,
      ST_IDLE = 3'h1,
      ST_ADDR = 3'h2,
      ST_SELECT = 3'h3,
      ST_SETTLE = 3'h4,
      ST_PULSE = 3'h5,
      ST_GAP = 3'h6
   } dpctl_state_e;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic rw_n;
      logic token_latch_select_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic doe;
   } dpctl_pins_s;

   localparam dpctl_pins_s PINS_IDLE = '{
      ce_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1, token_latch_select_n: 1'b1,
      addr: 13'h0000, dout: 9'h000, doe: 1'b0};
endpackage

// *** rtl/dpctl_sync.sv ***
// two-flop synchroniser for pin inputs
module dpctl_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // pins in, synchronised out
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         meta_reg <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end
endmodule // dpctl_sync

// *** rtl/dpctl_top.sv ***
// controller driving one port of the dual-port memory with token latches
//
// The register addresses and the strobed register port were decided locally.
module dpctl_top #(
   parameter bit IS_LEFT = 1'b1
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // software register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // memory port pins
   output logic [dpctl_pkg::ADDR_W-1:0] addr_o,
   output logic [dpctl_pkg::DATA_W-1:0] data_o,
   output logic data_oe_o,
   input wire logic [dpctl_pkg::DATA_W-1:0] data_i,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic rw_n_o,
   output logic token_latch_select_n_o,
   // flags from the memory
   input wire logic mbox_flag_n_i,
   input wire logic contention_n_i
);
   // cycle limits loaded into the down counter
   function automatic logic [7:0] cyc(input int n);
      cyc = (n < 1) ? 8'h01 : 8'(n);
   endfunction

   dpctl_pkg::dpctl_state_e state_reg, state_next;
   dpctl_pkg::dpctl_cmd_e op_reg, op_next;
   dpctl_pkg::dpctl_pins_s pins_reg, pins_next;
   logic [7:0] cnt_reg, cnt_next;
   logic acc_write_reg, acc_write_next;
   logic acc_token_reg, acc_token_next;
   logic [dpctl_pkg::ADDR_W-1:0] acc_addr_reg, acc_addr_next;
   logic [dpctl_pkg::DATA_W-1:0] acc_data_reg, acc_data_next;
   logic [dpctl_pkg::ADDR_W-1:0] addr_reg, addr_next;
   logic [dpctl_pkg::DATA_W-1:0] wdata_reg, wdata_next;
   logic [dpctl_pkg::DATA_W-1:0] rdata_reg, rdata_next;
   logic [3:0] init_idx_reg, init_idx_next;
   logic init_done_reg, init_done_next;
   logic done_reg, done_next;
   logic cont_reg, cont_next;
   logic owned_reg, owned_next;
   logic abort_reg, abort_next;
   logic [31:0] reg_rdata_reg, reg_rdata_next;
   logic done_set, cont_set;

   logic [dpctl_pkg::DATA_W-1:0] data_sync;
   logic mbox_flag_n_sync;
   logic contention_n_sync;

   dpctl_sync #(
      .WIDTH(dpctl_pkg::DATA_W),
      .RESET_VAL('0)
   ) u_data_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i(data_i),
      .sync_o(data_sync)
   );

   // flags idle high
   dpctl_sync #(
      .WIDTH(2),
      .RESET_VAL(2'h3)
   ) u_flag_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i({mbox_flag_n_i, contention_n_i}),
      .sync_o({mbox_flag_n_sync, contention_n_sync})
   );

   // software decode
   wire cmd_wr = reg_wr_i && (reg_addr_i == dpctl_pkg::REG_CMD);
   wire addr_wr = reg_wr_i && (reg_addr_i == dpctl_pkg::REG_ADDR);
   wire wdata_wr = reg_wr_i && (reg_addr_i == dpctl_pkg::REG_WDATA);
   wire status_rd = reg_rd_i && (reg_addr_i == dpctl_pkg::REG_STATUS);
   wire dpctl_pkg::dpctl_cmd_e cmd_in = dpctl_pkg::dpctl_cmd_e'(reg_wdata_i[2:0]);
   wire idle = (state_reg == dpctl_pkg::ST_IDLE);
   wire cnt_zero = (cnt_reg == 8'h00);
   wire [7:0] cnt_dec = cnt_reg - 8'h01;

   // mailbox addresses for this side
   wire [dpctl_pkg::ADDR_W-1:0] mbox_out_addr =
      IS_LEFT ? dpctl_pkg::MBOX_TO_RIGHT_ADDR : dpctl_pkg::MBOX_TO_LEFT_ADDR;
   wire [dpctl_pkg::ADDR_W-1:0] mbox_in_addr =
      IS_LEFT ? dpctl_pkg::MBOX_TO_LEFT_ADDR : dpctl_pkg::MBOX_TO_RIGHT_ADDR;
   // only low three bits select a latch; upper bits driven zero
   wire [dpctl_pkg::ADDR_W-1:0] token_addr =
      {{(dpctl_pkg::ADDR_W-dpctl_pkg::TOKEN_SEL_W){1'b0}},
       addr_reg[dpctl_pkg::TOKEN_SEL_W-1:0]};
   wire [dpctl_pkg::ADDR_W-1:0] init_addr =
      {{(dpctl_pkg::ADDR_W-dpctl_pkg::TOKEN_SEL_W){1'b0}},
       init_idx_reg[dpctl_pkg::TOKEN_SEL_W-1:0]};
   wire [dpctl_pkg::DATA_W-1:0] ones = '1;
   wire [dpctl_pkg::DATA_W-1:0] zeros = '0;
   wire init_last = (init_idx_reg == 4'(dpctl_pkg::TOKEN_COUNT));

   wire [31:0] status_word = {26'h000_0000,
      init_done_reg, owned_reg, ~mbox_flag_n_sync, cont_reg, done_reg, ~idle};
   wire [31:0] rd_mux =
      (reg_addr_i == dpctl_pkg::REG_CMD) ? {29'h0000_0000, op_reg} :
      (reg_addr_i == dpctl_pkg::REG_ADDR) ? {19'h0_0000, addr_reg} :
      (reg_addr_i == dpctl_pkg::REG_WDATA) ? {23'h00_0000, wdata_reg} :
      (reg_addr_i == dpctl_pkg::REG_RDATA) ? {23'h00_0000, rdata_reg} :
      (reg_addr_i == dpctl_pkg::REG_STATUS) ? status_word : 32'h0000_0000;

   // sticky status: a set in the clearing cycle survives
   assign done_next = done_set | (done_reg & ~status_rd);
   assign cont_next = cont_set | (cont_reg & ~status_rd);
   assign reg_rdata_next = reg_rd_i ? rd_mux : reg_rdata_reg;
   assign addr_next = addr_wr ? reg_wdata_i[dpctl_pkg::ADDR_W-1:0] : addr_reg;
   assign wdata_next = wdata_wr ? reg_wdata_i[dpctl_pkg::DATA_W-1:0] : wdata_reg;

   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      pins_next = pins_reg;
      cnt_next = cnt_reg;
      acc_write_next = acc_write_reg;
      acc_token_next = acc_token_reg;
      acc_addr_next = acc_addr_reg;
      acc_data_next = acc_data_reg;
      rdata_next = rdata_reg;
      init_idx_next = init_idx_reg;
      init_done_next = init_done_reg;
      owned_next = owned_reg;
      abort_next = abort_reg;
      done_set = 1'b0;
      cont_set = 1'b0;
      // withdraw a pending request while polling
      if (cmd_wr && (cmd_in == dpctl_pkg::CMD_TOKEN_RELEASE) &&
          (op_reg == dpctl_pkg::CMD_TOKEN_ACQUIRE) && !idle) begin
         abort_next = 1'b1;
      end
      case (state_reg)
         dpctl_pkg::ST_INIT: begin
            // free every latch before use: no reset inside the memory
            if (init_last) begin
               init_done_next = 1'b1;
               state_next = dpctl_pkg::ST_IDLE;
            end else begin
               acc_write_next = 1'b1;
               acc_token_next = 1'b1;
               acc_addr_next = init_addr;
               acc_data_next = ones;
               state_next = dpctl_pkg::ST_ADDR;
            end
         end
         dpctl_pkg::ST_IDLE: begin
            if (cmd_wr && (cmd_in != dpctl_pkg::CMD_NONE)) begin
               op_next = cmd_in;
               abort_next = 1'b0;
               state_next = dpctl_pkg::ST_ADDR;
               acc_token_next = 1'b0;
               acc_write_next = 1'b0;
               acc_addr_next = addr_reg;
               acc_data_next = wdata_reg;
               case (cmd_in)
                  dpctl_pkg::CMD_MEM_WRITE: acc_write_next = 1'b1;
                  dpctl_pkg::CMD_TOKEN_ACQUIRE: begin
                     acc_token_next = 1'b1;
                     acc_write_next = 1'b1;
                     acc_addr_next = token_addr;
                     acc_data_next = zeros;
                  end
                  dpctl_pkg::CMD_TOKEN_RELEASE: begin
                     acc_token_next = 1'b1;
                     acc_write_next = 1'b1;
                     acc_addr_next = token_addr;
                     acc_data_next = ones;
                  end
                  dpctl_pkg::CMD_TOKEN_READ: begin
                     acc_token_next = 1'b1;
                     acc_addr_next = token_addr;
                  end
                  dpctl_pkg::CMD_MBOX_SEND: begin
                     acc_write_next = 1'b1;
                     acc_addr_next = mbox_out_addr;
                  end
                  dpctl_pkg::CMD_MBOX_READ: acc_addr_next = mbox_in_addr;
                  default: acc_write_next = 1'b0;
               endcase
            end
         end
         dpctl_pkg::ST_ADDR: begin
            // address and data settle with both selects high
            pins_next = dpctl_pkg::PINS_IDLE;
            pins_next.addr = acc_addr_reg;
            pins_next.dout = acc_data_reg;
            pins_next.doe = acc_write_reg;
            state_next = dpctl_pkg::ST_SELECT;
         end
         dpctl_pkg::ST_SELECT: begin
            // exactly one select low, never both
            pins_next.ce_n = acc_token_reg;
            pins_next.token_latch_select_n = ~acc_token_reg;
            pins_next.oe_n = acc_write_reg;
            cnt_next = cyc(dpctl_pkg::SETTLE_CYC);
            state_next = dpctl_pkg::ST_SETTLE;
         end
         dpctl_pkg::ST_SETTLE: begin
            if (!cnt_zero) begin
               cnt_next = cnt_dec;
            end else if (!acc_token_reg && !contention_n_sync) begin
               // lost arbitration: hold the strobe off until granted
               cont_set = 1'b1;
            end else begin
               pins_next.rw_n = ~acc_write_reg;
               cnt_next = acc_write_reg ? cyc(dpctl_pkg::ACCESS_CYC) :
                                          cyc(dpctl_pkg::READ_CYC);
               state_next = dpctl_pkg::ST_PULSE;
            end
         end
         dpctl_pkg::ST_PULSE: begin
            if (!cnt_zero) begin
               cnt_next = cnt_dec;
            end else begin
               if (!acc_write_reg) begin
                  rdata_next = data_sync;
               end
               // strobes rise, data held one more cycle
               pins_next.ce_n = 1'b1;
               pins_next.oe_n = 1'b1;
               pins_next.rw_n = 1'b1;
               pins_next.token_latch_select_n = 1'b1;
               cnt_next = cyc(dpctl_pkg::GAP_CYC);
               state_next = dpctl_pkg::ST_GAP;
            end
         end
         dpctl_pkg::ST_GAP: begin
            pins_next.doe = 1'b0;
            if (!cnt_zero) begin
               cnt_next = cnt_dec;
            end else if (!init_done_reg) begin
               init_idx_next = init_idx_reg + 4'h1;
               state_next = dpctl_pkg::ST_INIT;
            end else if (op_reg == dpctl_pkg::CMD_TOKEN_ACQUIRE && abort_reg) begin
               op_next = dpctl_pkg::CMD_TOKEN_RELEASE;
               acc_write_next = 1'b1;
               acc_data_next = ones;
               state_next = dpctl_pkg::ST_ADDR;
            end else if (op_reg == dpctl_pkg::CMD_TOKEN_ACQUIRE &&
                         (acc_write_reg || rdata_reg[0])) begin
               // read back after the gap; a 1 means keep polling
               acc_write_next = 1'b0;
               state_next = dpctl_pkg::ST_ADDR;
            end else begin
               if (op_reg == dpctl_pkg::CMD_TOKEN_ACQUIRE) begin
                  owned_next = 1'b1;
               end
               if (op_reg == dpctl_pkg::CMD_TOKEN_RELEASE) begin
                  owned_next = 1'b0;
               end
               done_set = 1'b1;
               state_next = dpctl_pkg::ST_IDLE;
            end
         end
         default: begin
            pins_next = dpctl_pkg::PINS_IDLE;
            state_next = dpctl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_reg <= dpctl_pkg::ST_INIT;
         op_reg <= dpctl_pkg::CMD_NONE;
         pins_reg <= dpctl_pkg::PINS_IDLE;
         cnt_reg <= 8'h00;
         acc_write_reg <= 1'b0;
         acc_token_reg <= 1'b0;
         acc_addr_reg <= '0;
         acc_data_reg <= '0;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         pins_reg <= pins_next;
         cnt_reg <= cnt_next;
         acc_write_reg <= acc_write_next;
         acc_token_reg <= acc_token_next;
         acc_addr_reg <= acc_addr_next;
         acc_data_reg <= acc_data_next;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         addr_reg <= '0;
         wdata_reg <= '0;
         rdata_reg <= '0;
         init_idx_reg <= 4'h0;
         init_done_reg <= 1'b0;
         done_reg <= 1'b0;
         cont_reg <= 1'b0;
         owned_reg <= 1'b0;
         abort_reg <= 1'b0;
         reg_rdata_reg <= 32'h0000_0000;
      end else begin
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         init_idx_reg <= init_idx_next;
         init_done_reg <= init_done_next;
         done_reg <= done_next;
         cont_reg <= cont_next;
         owned_reg <= owned_next;
         abort_reg <= abort_next;
         reg_rdata_reg <= reg_rdata_next;
      end
   end

   assign reg_rdata_o = reg_rdata_reg;
   assign addr_o = pins_reg.addr;
   assign data_o = pins_reg.dout;
   assign data_oe_o = pins_reg.doe;
   assign ce_n_o = pins_reg.ce_n;
   assign oe_n_o = pins_reg.oe_n;
   assign rw_n_o = pins_reg.rw_n;
   assign token_latch_select_n_o = pins_reg.token_latch_select_n;
endmodule // dpctl_top

// *** bench/dpctl_props.sv ***
// pin-level assertions for the memory port controller
module dpctl_props (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // memory port pins
   input wire logic [dpctl_pkg::ADDR_W-1:0] addr_o,
   input wire logic [dpctl_pkg::DATA_W-1:0] data_o,
   input wire logic data_oe_o,
   input wire logic ce_n_o,
   input wire logic oe_n_o,
   input wire logic rw_n_o,
   input wire logic token_latch_select_n_o,
   input wire logic contention_n_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   wire logic sel_off = ce_n_o & token_latch_select_n_o;
   a_no_dual_select: assert property (ce_n_o || token_latch_select_n_o)
      else $error("both selects low");
   a_write_qual: assert property (!rw_n_o |-> (ce_n_o != token_latch_select_n_o) && oe_n_o && data_oe_o)
      else $error("write strobe without proper qualifiers");
   a_write_len: assert property ($fell(rw_n_o) |-> (!rw_n_o) [*7] ##1 rw_n_o)
      else $error("write pulse length wrong");
   a_write_data_hold: assert property (!rw_n_o && !$past(rw_n_o) |-> $stable(data_o))
      else $error("write data moved during pulse");
   a_addr_hold: assert property (!sel_off && !$past(sel_off) |-> $stable(addr_o))
      else $error("address moved while selected");
   a_read_qual: assert property (!oe_n_o |-> rw_n_o && !data_oe_o && !sel_off)
      else $error("output drive without select");
   a_read_len: assert property ($fell(oe_n_o) |-> (!oe_n_o) [*8])
      else $error("read pulse too short");
   a_select_gap: assert property ($rose(sel_off) |-> sel_off [*3])
      else $error("selects reasserted too soon");
   a_cont_hold: assert property ((!contention_n_i) [*4] ##0 rw_n_o |=> rw_n_o)
      else $error("write started while contention low");
endmodule // dpctl_props

bind dpctl_top dpctl_props dpctl_props_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
   .rw_n_o(rw_n_o), .token_latch_select_n_o(token_latch_select_n_o),
   .contention_n_i(contention_n_i));

// *** bench/dpctl_mem_model.sv ***
// behavioural dual-port memory with mailbox flags and token latches
module dpctl_mem_model (
   // left port
   input wire logic [12:0] l_addr_i,
   input wire logic [8:0] l_din_i,
   input wire logic l_ce_n_i,
   input wire logic l_oe_n_i,
   input wire logic l_rw_n_i,
   input wire logic l_token_latch_select_n_i,
   output logic [8:0] l_dout_o,
   output logic l_mbox_n_o,
   output logic l_cont_n_o,
   // right port
   input wire logic [12:0] r_addr_i,
   input wire logic [8:0] r_din_i,
   input wire logic r_ce_n_i,
   input wire logic r_oe_n_i,
   input wire logic r_rw_n_i,
   input wire logic r_token_latch_select_n_i,
   output logic [8:0] r_dout_o,
   output logic r_mbox_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] mem [0:8191];
   logic [1:0] owner [0:7];
   logic [1:0] req [0:7];
   logic l_tq, r_tq, r_first;
   logic [8:0] l_last, r_last;
   wire logic l_mw = !l_ce_n_i && !l_rw_n_i;
   wire logic r_mw = !r_ce_n_i && !r_rw_n_i;
   wire logic l_mr = !l_ce_n_i && !l_oe_n_i && l_rw_n_i;
   wire logic r_mr = !r_ce_n_i && !r_oe_n_i && r_rw_n_i;
   wire logic l_tw = !l_token_latch_select_n_i && l_ce_n_i && !l_rw_n_i;
   wire logic r_tw = !r_token_latch_select_n_i && r_ce_n_i && !r_rw_n_i;
   wire logic l_tr = !l_token_latch_select_n_i && l_ce_n_i && !l_oe_n_i && l_rw_n_i;
   wire logic r_tr = !r_token_latch_select_n_i && r_ce_n_i && !r_oe_n_i && r_rw_n_i;
   // latches power up held by the left side, so only an explicit init frees them
   initial begin
      l_mbox_n_o = 1'b1;
      r_mbox_n_o = 1'b1;
      for (int i = 0; i < 8; i++) begin
         owner[i] = 2'd1;
         req[i] = 2'd0;
      end
   end
   // side 1 is left, 2 is right; owner 0 means free
   task automatic tok_wr(input int s, input logic [2:0] i, input logic b);
      if (!b) begin
         if (owner[i] == 2'd0) owner[i] = 2'(s);
         else if (owner[i] != 2'(s)) req[i][s-1] = 1'b1;
      end else begin
         req[i][s-1] = 1'b0;
         if (owner[i] == 2'(s)) begin
            owner[i] = req[i][2-s] ? 2'(3 - s) : 2'd0;
            req[i][2-s] = 1'b0;
         end
      end
   endtask
   always @(negedge l_mw) begin
      mem[l_addr_i] = l_din_i;
      if (l_addr_i == 13'h1fff) r_mbox_n_o = 1'b0;
   end
   always @(negedge r_mw) begin
      mem[r_addr_i] = r_din_i;
      if (r_addr_i == 13'h1ffe) l_mbox_n_o = 1'b0;
   end
   always @(posedge l_mr) if (l_addr_i == 13'h1ffe) l_mbox_n_o = 1'b1;
   always @(posedge r_mr) if (r_addr_i == 13'h1fff) r_mbox_n_o = 1'b1;
   always @(negedge l_tw) tok_wr(1, l_addr_i[2:0], l_din_i[0]);
   always @(negedge r_tw) tok_wr(2, r_addr_i[2:0], r_din_i[0]);
   always @(posedge l_tr) l_tq = (owner[l_addr_i[2:0]] != 2'd1);
   always @(posedge r_tr) r_tq = (owner[r_addr_i[2:0]] != 2'd2);
   always @* if (l_mr || l_tr) l_last = l_mr ? mem[l_addr_i] : {9{l_tq}};
   always @* if (r_mr || r_tr) r_last = r_mr ? mem[r_addr_i] : {9{r_tq}};
   // released lines show the inverse, never a stale copy
   assign l_dout_o = (l_mr || l_tr) ? l_last : ~l_last;
   assign r_dout_o = (r_mr || r_tr) ? r_last : ~r_last;
   always @(negedge l_ce_n_i) r_first = !r_ce_n_i;
   assign l_cont_n_o = !(r_first && !l_ce_n_i && !r_ce_n_i && l_addr_i == r_addr_i);
endmodule // dpctl_mem_model

// *** bench/tb.sv ***
// self-checking bench for the memory port controller
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [12:0] l_addr;
   logic [12:0] r_addr = 13'h0000;
   logic [8:0] l_dout, l_dq, r_dout;
   logic [8:0] r_din = 9'h000;
   logic l_doe, l_ce_n, l_oe_n, l_rw_n, l_tls_n, l_mbox_n, l_cont_n, r_mbox_n;
   logic r_ce_n = 1'b1, r_oe_n = 1'b1, r_rw_n = 1'b1, r_tls_n = 1'b1;
   int n_mismatch = 0;
   int check_count = 0;
   wire logic [8:0] l_bus = l_doe ? l_dq : l_dout;
   always #5 clk = ~clk;
   dpctl_top #(.IS_LEFT(1'b1)) dpctl_top_inst (.clk_sys_i(clk), .rst_i(rst),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata), .addr_o(l_addr), .data_o(l_dq), .data_oe_o(l_doe),
      .data_i(l_bus), .ce_n_o(l_ce_n), .oe_n_o(l_oe_n), .rw_n_o(l_rw_n),
      .token_latch_select_n_o(l_tls_n), .mbox_flag_n_i(l_mbox_n), .contention_n_i(l_cont_n));
   dpctl_mem_model dpctl_mem_model_inst (.l_addr_i(l_addr), .l_din_i(l_bus), .l_ce_n_i(l_ce_n),
      .l_oe_n_i(l_oe_n), .l_rw_n_i(l_rw_n), .l_token_latch_select_n_i(l_tls_n),
      .l_dout_o(l_dout), .l_mbox_n_o(l_mbox_n), .l_cont_n_o(l_cont_n), .r_addr_i(r_addr),
      .r_din_i(r_din), .r_ce_n_i(r_ce_n), .r_oe_n_i(r_oe_n), .r_rw_n_i(r_rw_n),
      .r_token_latch_select_n_i(r_tls_n), .r_dout_o(r_dout), .r_mbox_n_o(r_mbox_n));
   task automatic wrap_up();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rr(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // every wait is bounded; running out ends the run as a failure
   task automatic idle();
      logic [31:0] s;
      @(posedge clk);
      for (int k = 0; k < 400; k++) begin
         rr(dpctl_pkg::REG_STATUS, s);
         if (s[dpctl_pkg::ST_BUSY_BIT] === 1'b0) return;
      end
      n_mismatch++;
      $display("CHECK FAILED busy expected 0 seen timeout");
      wrap_up();
   endtask
   task automatic cmd(input dpctl_pkg::dpctl_cmd_e c, input logic [12:0] a, input logic [8:0] d);
      rw(dpctl_pkg::REG_ADDR, {19'h0, a});
      rw(dpctl_pkg::REG_WDATA, {23'h0, d});
      rw(dpctl_pkg::REG_CMD, {29'h0, c});
      idle();
   endtask
   // right-side processor access: select, hold, sample, release, gap
   task automatic r_acc(input logic wr, input logic tok, input logic [12:0] a, input logic [8:0] d,
         output logic [8:0] q);
      @(posedge clk);
      r_addr <= a;
      r_din <= d;
      @(posedge clk);
      if (tok) r_tls_n <= 1'b0;
      else r_ce_n <= 1'b0;
      if (wr) r_rw_n <= 1'b0;
      else r_oe_n <= 1'b0;
      repeat (3) @(posedge clk);
      q = r_dout;
      @(posedge clk);
      {r_ce_n, r_tls_n, r_rw_n, r_oe_n} <= 4'hf;
      repeat (2) @(posedge clk);
   endtask
   task automatic t_init();
      logic [31:0] s;
      for (int k = 0; k < 300; k++) begin
         rr(dpctl_pkg::REG_STATUS, s);
         if (s[dpctl_pkg::ST_INIT_BIT] === 1'b1) break;
      end
      chk("init_done", 32'h0000_0001, 32'(s[dpctl_pkg::ST_INIT_BIT]));
      if (n_mismatch != 0) wrap_up();
      for (int i = 0; i < 8; i++) begin
         cmd(dpctl_pkg::CMD_TOKEN_READ, 13'(i), 9'h000);
         rr(dpctl_pkg::REG_RDATA, s);
         chk("token_free", 32'h0000_01ff, s);
      end
   endtask
   task automatic t_mem_mbox();
      logic [31:0] s;
      logic [8:0] q;
      cmd(dpctl_pkg::CMD_MEM_WRITE, 13'h1555, 9'h1a5);
      r_acc(1'b0, 1'b0, 13'h1555, 9'h000, q);
      chk("r_mem", 32'h0000_01a5, 32'(q));
      r_acc(1'b1, 1'b0, 13'h0000, 9'h05a, q);
      cmd(dpctl_pkg::CMD_MEM_READ, 13'h0000, 9'h000);
      rr(dpctl_pkg::REG_RDATA, s);
      chk("l_mem", 32'h0000_005a, s);
      cmd(dpctl_pkg::CMD_MBOX_SEND, 13'h0000, 9'h133);
      chk("r_flag_set", 32'h0000_0000, 32'(r_mbox_n));
      r_acc(1'b0, 1'b0, 13'h1fff, 9'h000, q);
      chk("r_msg", 32'h0000_0133, 32'(q));
      chk("r_flag_clr", 32'h0000_0001, 32'(r_mbox_n));
      r_acc(1'b1, 1'b0, 13'h1ffe, 9'h0c3, q);
      rr(dpctl_pkg::REG_STATUS, s);
      chk("l_pending", 32'h0000_0001, 32'(s[dpctl_pkg::ST_MBOX_BIT]));
      cmd(dpctl_pkg::CMD_MBOX_READ, 13'h0000, 9'h000);
      rr(dpctl_pkg::REG_RDATA, s);
      chk("l_msg", 32'h0000_00c3, s);
      rr(dpctl_pkg::REG_STATUS, s);
      chk("l_cleared", 32'h0000_0000, 32'(s[dpctl_pkg::ST_MBOX_BIT]));
      rr(8'h14, s);
      chk("unmapped", 32'h0000_0000, s);
   endtask
   task automatic t_token();
      logic [31:0] s;
      logic [8:0] q;
      cmd(dpctl_pkg::CMD_TOKEN_ACQUIRE, 13'h1ffd, 9'h000);
      rr(dpctl_pkg::REG_STATUS, s);
      chk("owned", 32'h0000_0001, 32'(s[dpctl_pkg::ST_OWNED_BIT]));
      r_acc(1'b0, 1'b1, 13'h0005, 9'h000, q);
      chk("r_denied", 32'h0000_01ff, 32'(q));
      r_acc(1'b1, 1'b1, 13'h0005, 9'h0fe, q);
      cmd(dpctl_pkg::CMD_TOKEN_RELEASE, 13'h0005, 9'h000);
      r_acc(1'b0, 1'b1, 13'h0005, 9'h000, q);
      chk("r_handover", 32'h0000_0000, 32'(q));
      rw(dpctl_pkg::REG_CMD, {29'h0, dpctl_pkg::CMD_TOKEN_ACQUIRE});
      repeat (60) @(posedge clk);
      rr(dpctl_pkg::REG_STATUS, s);
      chk("polling", 32'h0000_0001, 32'(s[dpctl_pkg::ST_BUSY_BIT]));
      rw(dpctl_pkg::REG_CMD, {29'h0, dpctl_pkg::CMD_TOKEN_RELEASE});
      idle();
      rr(dpctl_pkg::REG_STATUS, s);
      chk("withdrawn", 32'h0000_0000, 32'(s[dpctl_pkg::ST_OWNED_BIT]));
      r_acc(1'b1, 1'b1, 13'h0005, 9'h001, q);
      cmd(dpctl_pkg::CMD_TOKEN_READ, 13'h0005, 9'h000);
      rr(dpctl_pkg::REG_RDATA, s);
      chk("l_free", 32'h0000_01ff, s);
   endtask
   task automatic t_cont();
      logic [31:0] s;
      logic [8:0] q;
      @(posedge clk);
      r_addr <= 13'h0777;
      r_ce_n <= 1'b0;
      r_oe_n <= 1'b0;
      rw(dpctl_pkg::REG_ADDR, 32'h0000_0777);
      rw(dpctl_pkg::REG_WDATA, 32'h0000_00e1);
      rw(dpctl_pkg::REG_CMD, {29'h0, dpctl_pkg::CMD_MEM_WRITE});
      repeat (30) @(posedge clk);
      rr(dpctl_pkg::REG_STATUS, s);
      chk("held", 32'h0000_0003, 32'({s[dpctl_pkg::ST_CONT_BIT], s[dpctl_pkg::ST_BUSY_BIT]}));
      @(posedge clk);
      r_ce_n <= 1'b1;
      r_oe_n <= 1'b1;
      idle();
      r_acc(1'b0, 1'b0, 13'h0777, 9'h000, q);
      chk("late_write", 32'h0000_00e1, 32'(q));
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      chk("rdata_reset", 32'h0000_0000, reg_rdata);
      t_init();
      t_mem_mbox();
      t_token();
      t_cont();
      wrap_up();
   end
endmodule // tb
